// ### design/pmm_power_mode_manager.sv
`default_nettype none
module pmm_power_mode_manager (
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    input  wire logic       pd_write_i,
    input  wire logic [2:0] power_down_select_i,
    input  wire logic       standby_req_i,
    input  wire logic [2:0] slow_clock_source_i,
    input  wire logic [1:0] osc_start_sel_i,
    input  wire logic       keep_xtal_retention_i,
    input  wire logic       xtal_running_i,
    input  wire logic       wake_pin_i,
    input  wire logic       timer_tick_i,
    input  wire logic       timer_early_i,
    input  wire logic       comparator_i,
    input  wire logic       radio_interrupt_i,
    input  wire logic       auxiliary_interrupt_i,
    input  wire logic       flag_read_i,
    output logic [2:0]      mode_o,
    output logic            cpu_clock_en_o,
    output logic            system_reset_o,
    output logic            voltage_regulator_en_o,
    output logic            fast_crystal_oscillator_en_o,
    output logic            fast_rc_oscillator_en_o,
    output logic            prog_mem_pwr_o,
    output logic            register_pwr_o,
    output logic            data_mem_full_pwr_o,
    output logic            data_mem_retain_pwr_o,
    output logic            slow_clock_en_o,
    output logic            wake_pin_flag_o,
    output logic            wake_tick_flag_o,
    output logic            wake_cmp_flag_o
);
    pmm_cnt_if cnt ();

    pmm_pkg::pmm_state_type state;
    pmm_pkg::pmm_state_type next_state;
    logic [pmm_pkg::SY_W-1:0] async_in;
    logic [pmm_pkg::SY_W-1:0] sync_in;
    logic                     reset_pend;
    logic                     prestart;
    logic                     xtal_at_entry;

    assign async_in = {xtal_running_i, auxiliary_interrupt_i,
                       radio_interrupt_i, comparator_i, timer_early_i,
                       timer_tick_i, wake_pin_i};

    pmm_sync #(
        .W (pmm_pkg::SY_W)
    ) u_sync (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .async_i (async_in),
        .sync_o  (sync_in)
    );

    pmm_wake_timer u_timer (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .cnt    (cnt)
    );

    // synchronised wake sources and crystal running status
    logic s_pin;
    logic s_tick;
    logic s_early;
    logic s_cmp;
    logic s_radio;
    logic s_aux;
    logic s_xtal;
    assign s_pin   = sync_in[pmm_pkg::SY_PIN];
    assign s_tick  = sync_in[pmm_pkg::SY_TICK];
    assign s_early = sync_in[pmm_pkg::SY_EARLY];
    assign s_cmp   = sync_in[pmm_pkg::SY_CMP];
    assign s_radio = sync_in[pmm_pkg::SY_RADIO];
    assign s_aux   = sync_in[pmm_pkg::SY_AUX];
    assign s_xtal  = sync_in[pmm_pkg::SY_XTAL];

    // timers run whenever a real slow clock source is chosen
    logic timers_on;
    assign timers_on = (slow_clock_source_i != pmm_pkg::SLOW_NONE)
                    && (slow_clock_source_i != pmm_pkg::SLOW_RSVD_A)
                    && (slow_clock_source_i != pmm_pkg::SLOW_RSVD_B);

    // power-down request decode
    logic pd_go;
    logic pd_reg;
    assign pd_go  = pd_write_i && (state == pmm_pkg::S_ACTIVE);
    assign pd_reg = power_down_select_i == pmm_pkg::PD_REG_RET;

    // wake source qualification per mode
    logic in_timed;
    logic in_pin_only;
    logic in_standby;
    assign in_timed    = (state == pmm_pkg::S_MEM_ON)
                      || (state == pmm_pkg::S_REG_ON);
    assign in_pin_only = (state == pmm_pkg::S_DEEP)
                      || (state == pmm_pkg::S_MEM_OFF)
                      || (state == pmm_pkg::S_REG_OFF);
    assign in_standby  = state == pmm_pkg::S_STANDBY;

    logic wake_by_pin;
    logic wake_by_tick;
    logic wake_by_cmp;
    logic wake_by_irq;
    logic wake_any;
    assign wake_by_pin  = s_pin && (in_timed || in_pin_only || in_standby);
    assign wake_by_tick = s_tick && (in_timed
                                     || (in_standby && timers_on));
    assign wake_by_cmp  = s_cmp && in_timed;
    assign wake_by_irq  = (s_radio || s_aux) && in_standby;
    assign wake_any     = wake_by_pin || wake_by_tick
                       || wake_by_cmp || wake_by_irq;

    // short pre-start choice for a tick wake
    logic short_pre;
    assign short_pre = (osc_start_sel_i == pmm_pkg::OSC_RC_ONLY)
                    || (state == pmm_pkg::S_REG_ON
                        && keep_xtal_retention_i
                        && xtal_at_entry);

    // wake delay chosen by cause and mode
    logic [pmm_pkg::CNT_W-1:0] wake_len;
    assign wake_len =
        in_standby ? pmm_pkg::CNT_W'(pmm_pkg::STANDBY_RESUME_CYC) :
        !wake_by_tick ? pmm_pkg::CNT_W'(pmm_pkg::PIN_START_CYC - pmm_pkg::PIN_MARGIN_CYC) :
        short_pre ? pmm_pkg::CNT_W'(pmm_pkg::SHORT_PRESTART_CYC) :
        prestart ? pmm_pkg::CNT_W'(pmm_pkg::TICK_READY_CYC) :
        pmm_pkg::CNT_W'(pmm_pkg::PIN_START_CYC - pmm_pkg::PIN_MARGIN_CYC);

    // power-down target decoded from the written code; reserved codes stay active
    pmm_pkg::pmm_state_type pd_target;
    logic                   enter_pd;
    assign pd_target =
        (power_down_select_i == pmm_pkg::PD_DEEP)    ? pmm_pkg::S_DEEP    :
        (power_down_select_i == pmm_pkg::PD_MEM_OFF) ? pmm_pkg::S_MEM_OFF :
        (power_down_select_i == pmm_pkg::PD_MEM_ON)  ? pmm_pkg::S_MEM_ON  :
        !pd_reg   ? pmm_pkg::S_ACTIVE :
        timers_on ? pmm_pkg::S_REG_ON : pmm_pkg::S_REG_OFF;
    assign enter_pd = (state == pmm_pkg::S_ACTIVE) && (next_state != pmm_pkg::S_ACTIVE);

    // timer is loaded on the wake edge, so the delay counts from there
    assign cnt.start    = wake_any;
    assign cnt.load_val = wake_len;

    // next state: power-down from active, wake from any saving mode
    always_comb begin
        next_state = state;
        unique case (state)
            pmm_pkg::S_ACTIVE: begin
                if (pd_go && (pd_target != pmm_pkg::S_ACTIVE)) begin
                    next_state = pd_target;
                end else if (standby_req_i) begin
                    next_state = pmm_pkg::S_STANDBY;
                end
            end
            pmm_pkg::S_WAKE: begin
                if (cnt.done) begin
                    next_state = pmm_pkg::S_ACTIVE;
                end
            end
            pmm_pkg::S_DEEP, pmm_pkg::S_MEM_OFF, pmm_pkg::S_MEM_ON,
            pmm_pkg::S_REG_OFF, pmm_pkg::S_REG_ON, pmm_pkg::S_STANDBY: begin
                if (wake_any) begin
                    next_state = pmm_pkg::S_WAKE;
                end
            end
        endcase
    end

    // deep sleep and memory retention lose the registers, so their wakes reset
    logic wake_resets;
    logic next_prestart;
    assign wake_resets = (state == pmm_pkg::S_DEEP)
                      || (state == pmm_pkg::S_MEM_OFF)
                      || (state == pmm_pkg::S_MEM_ON);

    // early tick warning starts regulator and crystal before the tick
    assign next_prestart = enter_pd ? 1'b0 :
                           (s_early && in_timed) ? 1'b1 :
                           (state == pmm_pkg::S_WAKE) ? 1'b0 :
                           prestart;

    // state and wake bookkeeping
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state         <= pmm_pkg::S_ACTIVE;
            reset_pend    <= 1'b0;
            xtal_at_entry <= 1'b0;
            prestart      <= 1'b0;
        end else begin
            state <= next_state;
            if (cnt.start) begin
                reset_pend <= wake_resets;
            end
            if (enter_pd) begin
                xtal_at_entry <= s_xtal;
            end
            prestart <= next_prestart;
        end
    end

    // power decode for the state about to be entered
    logic nx_run;
    logic nx_reg_ret;
    logic nx_mem_ret;
    logic nx_cpu;
    logic nx_voltage_regulator;
    logic nx_xtal;
    logic nx_reg;
    logic nx_dret;
    logic nx_slow;
    assign nx_run     = (next_state == pmm_pkg::S_ACTIVE)
                     || (next_state == pmm_pkg::S_STANDBY)
                     || (next_state == pmm_pkg::S_WAKE);
    assign nx_reg_ret = (next_state == pmm_pkg::S_REG_ON)
                     || (next_state == pmm_pkg::S_REG_OFF);
    assign nx_mem_ret = (next_state == pmm_pkg::S_MEM_ON)
                     || (next_state == pmm_pkg::S_MEM_OFF);
    assign nx_cpu     = next_state == pmm_pkg::S_ACTIVE;
    assign nx_voltage_regulator    = nx_run || next_prestart;
    assign nx_xtal    = nx_run || next_prestart
                     || (nx_reg_ret && keep_xtal_retention_i);
    assign nx_reg     = nx_run || nx_reg_ret;
    assign nx_dret    = nx_reg || nx_mem_ret;
    assign nx_slow    = (next_state == pmm_pkg::S_MEM_ON)
                     || (next_state == pmm_pkg::S_REG_ON)
                     || (nx_run && timers_on);

    // wake cause flags: a new wake wins over a read or an entry clear
    logic flag_clear;
    logic next_pin_flag;
    logic next_tick_flag;
    logic next_cmp_flag;
    assign flag_clear     = flag_read_i || enter_pd;
    assign next_pin_flag  = wake_by_pin || (wake_pin_flag_o && !flag_clear);
    assign next_tick_flag = wake_by_tick || (wake_tick_flag_o && !flag_clear);
    assign next_cmp_flag  = wake_by_cmp || (wake_cmp_flag_o && !flag_clear);

    // every output is a flop of the decode above
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            mode_o                       <= 3'h0;
            cpu_clock_en_o               <= 1'b1;
            system_reset_o               <= 1'b0;
            voltage_regulator_en_o       <= 1'b1;
            fast_crystal_oscillator_en_o <= 1'b1;
            fast_rc_oscillator_en_o      <= 1'b1;
            prog_mem_pwr_o               <= 1'b1;
            register_pwr_o               <= 1'b1;
            data_mem_full_pwr_o          <= 1'b1;
            data_mem_retain_pwr_o        <= 1'b1;
            slow_clock_en_o              <= 1'b0;
            wake_pin_flag_o              <= 1'b0;
            wake_tick_flag_o             <= 1'b0;
            wake_cmp_flag_o              <= 1'b0;
        end else begin
            mode_o                       <= next_state;
            cpu_clock_en_o               <= nx_cpu;
            system_reset_o               <= (state == pmm_pkg::S_WAKE) && cnt.done && reset_pend;
            voltage_regulator_en_o       <= nx_voltage_regulator;
            fast_crystal_oscillator_en_o <= nx_xtal;
            fast_rc_oscillator_en_o      <= nx_run;
            prog_mem_pwr_o               <= nx_run;
            register_pwr_o               <= nx_reg;
            data_mem_full_pwr_o          <= nx_reg;
            data_mem_retain_pwr_o        <= nx_dret;
            slow_clock_en_o              <= nx_slow;
            wake_pin_flag_o              <= next_pin_flag;
            wake_tick_flag_o             <= next_tick_flag;
            wake_cmp_flag_o              <= next_cmp_flag;
        end
    end

    // memory retention timers-on wakes always reset the system
    property p_mem_reset;
        @(posedge mclk_i) disable iff (rst_i)
        (state == pmm_pkg::S_MEM_ON) && wake_any |=> reset_pend;
    endproperty
    a_mem_reset: assert property (p_mem_reset) else $error("memory retention wake without reset");

    // register retention wakes resume in place
    property p_reg_resume;
        @(posedge mclk_i) disable iff (rst_i)
        ((state == pmm_pkg::S_REG_ON) || (state == pmm_pkg::S_REG_OFF)) && wake_any |=> !reset_pend;
    endproperty
    a_reg_resume: assert property (p_reg_resume) else $error("register retention wake would reset");

    // timers-off register retention ignores everything but the pin
    property p_reg_off_pin;
        @(posedge mclk_i) disable iff (rst_i)
        (state == pmm_pkg::S_REG_OFF) && !s_pin |=> (state == pmm_pkg::S_REG_OFF);
    endproperty
    a_reg_off_pin: assert property (p_reg_off_pin) else $error("timers-off retention left without pin");

    // standby keeps supplies up with the processor clock stopped
    property p_standby_power;
        @(posedge mclk_i) disable iff (rst_i)
        (state == pmm_pkg::S_STANDBY) |-> !cpu_clock_en_o && voltage_regulator_en_o
                                        && fast_crystal_oscillator_en_o && prog_mem_pwr_o;
    endproperty
    a_standby_power: assert property (p_standby_power) else $error("standby power set wrong");

    // comparator alone never ends standby
    property p_standby_no_cmp;
        @(posedge mclk_i) disable iff (rst_i)
        (state == pmm_pkg::S_STANDBY) && s_cmp && !s_pin && !s_tick && !s_radio && !s_aux
        |=> (state == pmm_pkg::S_STANDBY);
    endproperty
    a_standby_no_cmp: assert property (p_standby_no_cmp) else $error("comparator woke standby");

    // standby resume is a handful of cycles
    property p_standby_resume;
        @(posedge mclk_i) disable iff (rst_i)
        (state == pmm_pkg::S_STANDBY) && wake_any |=> ##[1:8] (state == pmm_pkg::S_ACTIVE);
    endproperty
    a_standby_resume: assert property (p_standby_resume) else $error("standby resume too slow");

    // active mode has everything powered and the processor clocked
    property p_active_power;
        @(posedge mclk_i) disable iff (rst_i)
        (state == pmm_pkg::S_ACTIVE) |-> cpu_clock_en_o && register_pwr_o
                                       && data_mem_full_pwr_o && prog_mem_pwr_o;
    endproperty
    a_active_power: assert property (p_active_power) else $error("active mode not fully powered");
endmodule : pmm_power_mode_manager
`default_nettype wire

// ### pkg/pmm_pkg.sv
`default_nettype none
package pmm_pkg;
    // power_down_select codes
    localparam logic [2:0] PD_ACTIVE   = 3'h0;
    localparam logic [2:0] PD_DEEP     = 3'h1;
    localparam logic [2:0] PD_MEM_OFF  = 3'h2;
    localparam logic [2:0] PD_MEM_ON   = 3'h3;
    localparam logic [2:0] PD_REG_RET  = 3'h4;
    // slow_clock_control source codes that stop the slow clock except in memory retention timers on
    localparam logic [2:0] SLOW_RSVD_A = 3'h5;
    localparam logic [2:0] SLOW_RSVD_B = 3'h6;
    localparam logic [2:0] SLOW_NONE   = 3'h7;
    // core_clock_control oscillator start field: fast rc only
    localparam logic [1:0] OSC_RC_ONLY = 2'h1;
    // timing
    localparam int CLK_MHZ            = 40;
    localparam int CLK_PERIOD_NS      = 25;
    localparam int PIN_START_US       = 100;
    localparam int STANDBY_RESUME_NS  = 100;
    localparam int PIN_START_CYC      = PIN_START_US * CLK_MHZ;
    localparam int PIN_MARGIN_CYC     = 16;
    localparam int STANDBY_RESUME_CYC = STANDBY_RESUME_NS / CLK_PERIOD_NS;
    localparam int SHORT_PRESTART_CYC = 4;
    localparam int TICK_READY_CYC     = 1;
    localparam int CNT_W              = 12;
    // synchroniser bit positions
    localparam int SY_PIN   = 0;
    localparam int SY_TICK  = 1;
    localparam int SY_EARLY = 2;
    localparam int SY_CMP   = 3;
    localparam int SY_RADIO = 4;
    localparam int SY_AUX   = 5;
    localparam int SY_XTAL  = 6;
    localparam int SY_W     = 7;
    // controller states
    typedef enum logic [2:0] {
        S_ACTIVE  = 3'h0,
        S_DEEP    = 3'h1,
        S_MEM_OFF = 3'h2,
        S_MEM_ON  = 3'h3,
        S_REG_OFF = 3'h4,
        S_REG_ON  = 3'h5,
        S_STANDBY = 3'h6,
        S_WAKE    = 3'h7
    } pmm_state_type;
endpackage : pmm_pkg
`default_nettype wire

// ### pkg/pmm_cnt_if.sv
`default_nettype none
interface pmm_cnt_if;
    logic                     start;
    logic [pmm_pkg::CNT_W-1:0] load_val;
    logic                     done;
    modport ctrl  (output start, output load_val, input done);
    modport timer (input start, input load_val, output done);
endinterface : pmm_cnt_if
`default_nettype wire

// ### design/pmm_sync.sv
`default_nettype none
module pmm_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta;

    // two-stage synchroniser, first stage feeds only the second
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            meta   <= '0;
            sync_o <= '0;
        end else begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end
endmodule : pmm_sync
`default_nettype wire

// ### design/pmm_wake_timer.sv
`default_nettype none
module pmm_wake_timer (
    input  wire logic mclk_i,
    input  wire logic rst_i,
    pmm_cnt_if.timer  cnt
);
    logic [pmm_pkg::CNT_W-1:0] count;
    logic                      last;

    assign last = (count == pmm_pkg::CNT_W'(1));

    // down counter, done pulses one cycle as it expires
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            count    <= '0;
            cnt.done <= 1'b0;
        end else if (cnt.start) begin
            count    <= cnt.load_val;
            cnt.done <= 1'b0;
        end else begin
            count    <= (count != '0) ? count - pmm_pkg::CNT_W'(1) : count;
            cnt.done <= last;
        end
    end
endmodule : pmm_wake_timer
`default_nettype wire

// ### tb/pmm_core_model.sv
`default_nettype none
module pmm_core_model (
    input  wire logic       mclk_i,
    output logic            pd_write_o,
    output logic [2:0]      select_o,
    output logic            standby_o,
    output logic [5:0]      wake_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle core: no request, no wake source
    initial begin
        pd_write_o = 1'b0;
        select_o   = 3'h0;
        standby_o  = 1'b0;
        wake_o     = 6'h0;
    end
    // one-cycle power-down write; fast rc assumed on before deep sleep
    task automatic power_down(input logic [2:0] code);
        @(negedge mclk_i);
        select_o   = code;
        pd_write_o = 1'b1;
        @(negedge mclk_i);
        pd_write_o = 1'b0;
    endtask : power_down
    // standby request, as after an early wake
    task automatic standby();
        @(negedge mclk_i);
        standby_o = 1'b1;
        @(negedge mclk_i);
        standby_o = 1'b0;
    endtask : standby
    // wake source held four cycles: 0 pin 1 tick 2 early 3 cmp 4 radio 5 aux
    task automatic wake(input int idx);
        @(negedge mclk_i);
        wake_o[idx] = 1'b1;
        repeat (4) @(negedge mclk_i);
        wake_o[idx] = 1'b0;
    endtask : wake
endmodule : pmm_core_model
`default_nettype wire

// ### tb/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       mclk, rst, pd_wr, stby, cpu_en, sys_rst, voltage_regulator, xtal, prog, regp, dfull, rst_seen;
    logic       keep, xrun, fread, rc, dret, slck, f_pin, f_tick, f_cmp;
    logic [1:0] osc;
    logic [2:0] sel, slow, mode;
    logic [5:0] wk;
    int         n_errors, total_checks;
    pmm_core_model core (.mclk_i(mclk), .pd_write_o(pd_wr), .select_o(sel), .standby_o(stby), .wake_o(wk));
    pmm_power_mode_manager DUT (
        .mclk_i(mclk), .rst_i(rst), .pd_write_i(pd_wr), .power_down_select_i(sel), .standby_req_i(stby),
        .slow_clock_source_i(slow), .osc_start_sel_i(osc), .keep_xtal_retention_i(keep),
        .xtal_running_i(xrun), .wake_pin_i(wk[0]), .timer_tick_i(wk[1]), .timer_early_i(wk[2]),
        .comparator_i(wk[3]), .radio_interrupt_i(wk[4]), .auxiliary_interrupt_i(wk[5]), .flag_read_i(fread),
        .mode_o(mode), .cpu_clock_en_o(cpu_en), .system_reset_o(sys_rst), .voltage_regulator_en_o(voltage_regulator),
        .fast_crystal_oscillator_en_o(xtal), .fast_rc_oscillator_en_o(rc), .prog_mem_pwr_o(prog),
        .register_pwr_o(regp), .data_mem_full_pwr_o(dfull), .data_mem_retain_pwr_o(dret),
        .slow_clock_en_o(slck), .wake_pin_flag_o(f_pin), .wake_tick_flag_o(f_tick), .wake_cmp_flag_o(f_cmp));
    // clock at 40 MHz
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic chk(input string name, input logic [3:0] exp, input logic [3:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic results();
        if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results
    // bounded wait for active mode, noting any system reset on the way
    task automatic wait_active(input int bound);
        rst_seen = 1'b0;
        for (int i = 0; i <= bound; i++) begin
            @(negedge mclk);
            if (sys_rst === 1'b1) rst_seen = 1'b1;
            if (mode === 3'h0 && cpu_en === 1'b1) return;
        end
        chk("wake to active", 4'h1, 4'h0);
        results();
    endtask : wait_active
    // compare the wake cause flags, then clear them by a read
    task automatic read_flags(input logic [3:0] exp);
        chk("wake flags", exp, {1'h0, f_pin, f_tick, f_cmp});
        @(negedge mclk);
        fread = 1'b1;
        @(negedge mclk);
        fread = 1'b0;
        @(negedge mclk);
        chk("flags cleared", 4'h0, {1'h0, f_pin, f_tick, f_cmp});
    endtask : read_flags
    task automatic s_reg_on();
        slow = 3'h1;
        core.power_down(3'h4);
        repeat (4) @(negedge mclk);
        chk("reg ret power", 4'he, {regp, dfull, slck, xtal});
        chk("reg ret clock", 4'h0, {3'h0, cpu_en});
        core.wake(3);
        wait_active(pmm_pkg::PIN_START_CYC);
        chk("reg ret reset", 4'h0, {3'h0, rst_seen});
        read_flags(4'h1);
    endtask : s_reg_on
    task automatic s_reg_off();
        slow = pmm_pkg::SLOW_NONE;
        core.power_down(3'h4);
        repeat (4) @(negedge mclk);
        chk("reg off power", 4'h2, {2'h0, regp, slck});
        core.wake(1);
        repeat (20) @(negedge mclk);
        chk("tick ignored", 4'h1, {3'h0, mode !== 3'h0});
        core.wake(0);
        wait_active(pmm_pkg::PIN_START_CYC);
        chk("reg off reset", 4'h0, {3'h0, rst_seen});
        read_flags(4'h4);
    endtask : s_reg_off
    task automatic s_mem_on();
        slow = 3'h1;
        core.power_down(3'h3);
        core.wake(0);
        wait_active(pmm_pkg::PIN_START_CYC);
        chk("mem ret reset", 4'h1, {3'h0, rst_seen});
    endtask : s_mem_on
    // deep sleep or memory retention timers off: pin only, wake resets
    task automatic s_low(input logic [2:0] code);
        slow = 3'h1;
        core.power_down(code);
        repeat (4) @(negedge mclk);
        chk("low power", {3'h0, code == 3'h2}, {regp, dfull, rc, dret});
        core.wake(1);
        repeat (20) @(negedge mclk);
        chk("low tick ignored", 4'h1, {3'h0, mode !== 3'h0});
        core.wake(0);
        wait_active(pmm_pkg::PIN_START_CYC);
        chk("low reset", 4'h1, {3'h0, rst_seen});
    endtask : s_low
    // tick wakes from register retention timers on
    task automatic s_tick();
        slow = 3'h1;
        keep = 1'b1;
        core.power_down(3'h4);
        repeat (4) @(negedge mclk);
        chk("kept crystal", 4'h1, {3'h0, xtal});
        core.wake(2);
        chk("pre-start", 4'h3, {2'h0, voltage_regulator, xtal});
        core.wake(1);
        wait_active(12);
        read_flags(4'h2);
        keep = 1'b0;
        osc = pmm_pkg::OSC_RC_ONLY;
        core.power_down(3'h4);
        core.wake(1);
        wait_active(12);
        osc = 2'h0;
        keep = 1'b1;
        xrun = 1'b0;
        repeat (4) @(negedge mclk);
        core.power_down(3'h4);
        core.wake(1);
        repeat (20) @(negedge mclk);
        chk("no short pre-start", 4'h1, {3'h0, mode !== 3'h0});
        wait_active(pmm_pkg::PIN_START_CYC);
        xrun = 1'b1;
        keep = 1'b0;
    endtask : s_tick
    task automatic s_standby(input int src);
        core.standby();
        repeat (4) @(negedge mclk);
        chk("standby power", 4'h7, {cpu_en, voltage_regulator, xtal, prog});
        core.wake(3);
        repeat (10) @(negedge mclk);
        chk("cmp ignored", 4'h1, {3'h0, mode !== 3'h0});
        core.wake(src);
        wait_active(pmm_pkg::STANDBY_RESUME_CYC + 8);
        chk("standby reset", 4'h0, {3'h0, rst_seen});
    endtask : s_standby
    // reset for 20 cycles, then the scenarios
    initial begin
        n_errors = 0;
        total_checks = 0;
        rst = 1'b1;
        slow = 3'h1;
        osc = 2'h0;
        keep = 1'b0;
        xrun = 1'b1;
        fread = 1'b0;
        repeat (20) @(negedge mclk);
        rst = 1'b0;
        repeat (2) @(negedge mclk);
        chk("active power", 4'hf, {cpu_en, voltage_regulator, prog, dfull});
        s_reg_on();
        s_reg_off();
        s_mem_on();
        s_low(3'h1);
        s_low(3'h2);
        s_tick();
        s_standby(4);
        s_standby(5);
        results();
    end
endmodule : tb_top
`default_nettype wire
